/* hdl/pcd_handler.sv */
// code change and code disable command handler with apb registers
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module pcd_handler
   import pcd_pkg::*;
(
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic irq_out,
   output logic se_eval_out
);
   // per code storage (kept by non volatile storage in a real card)
   logic [63:0] code_val [NUM_CODES];
   logic [1:0] retry [NUM_CODES];
   logic [NUM_CODES-1:0] code_dis;
   logic [NUM_CODES-1:0] code_blk;
   logic [NUM_CODES-1:0] subst_used;
   logic [4:0] subst_ref [NUM_CODES];
   logic [7:0] qual [NUM_CODES];
   logic [63:0] old_code, new_code;
   logic [7:0] cmd_ins, cmd_lc, cmd_p1, cmd_p2;
   logic [15:0] sw;
   logic [3:0] irq_st, irq_mask;
   logic [NUM_CODES-1:0] file_refs;
   logic busy, start, prov_we;
   logic [4:0] prov_idx;
   pcd_state_t state, next_state;
   logic [15:0] next_sw;
   logic [3:0] next_irq_st;
   logic [4:0] idx;
   logic apb_wr, apb_rd;

   function automatic logic [31:0] word_sel(input logic [63:0] v, input logic hi);
      word_sel = hi ? v[63:32] : v[31:0];
   endfunction

   assign apb_wr = psel_in && penable_in && pwrite_in;
   assign apb_rd = psel_in && penable_in && !pwrite_in;
   assign idx = cmd_p2[4:0];

   // execution state machine
   always_comb begin
      next_state = state;
      case (state)
         PCD_IDLE: begin
            if (start) begin
               next_state = PCD_EXEC;
            end
         end
         PCD_EXEC: next_state = PCD_DONE;
         PCD_DONE: next_state = PCD_IDLE;
         default: next_state = PCD_IDLE;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         state <= PCD_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // p1 coding check for the disable command
   function automatic logic p1_legal(input logic [7:0] p1);
      p1_legal = (p1 == P1_PLAIN) ||
         (p1[P1_SUBST_BIT] && p1[6:5] == 2'h0 && p1[4:0] != 5'h00); // [RL11] [RL12]
   endfunction

   // p2 reference check, top bit ignored
   function automatic logic p2_legal(input logic [7:0] p2);
      p2_legal = (p2[6:5] == 2'h0) && (p2[4:0] != 5'h00); // [RL17]
   endfunction

   // command decode and answer
   logic p2_ok, p1_ok, subst_req, is_chg, is_dis, match, fail_blk;
   logic [3:0] irq_ev, irq_clr;
   always_comb begin
      p2_ok = p2_legal(cmd_p2); // [RL17]
      subst_req = cmd_p1[P1_SUBST_BIT]; // [RL12]
      p1_ok = p1_legal(cmd_p1); // [RL11] [RL12]
      is_chg = (cmd_ins == CMD_CHANGE);
      is_dis = (cmd_ins == CMD_DISABLE);
      match = (old_code == code_val[idx]);
      fail_blk = (retry[idx] == 2'h1);
      next_sw = sw;
      irq_ev = 4'h0;
      if (state == PCD_EXEC) begin
         irq_ev[IRQ_DONE] = 1'b1;
         if (!is_chg && !is_dis) begin
            next_sw = SW_INS;
         end else if (is_chg && cmd_lc != LC_CHANGE) begin
            next_sw = SW_LEN; // [RL6] [RL19]
         end else if (is_dis && cmd_lc != LC_DISABLE) begin
            next_sw = SW_LEN; // [RL10] [RL19]
         end else if (!p2_ok || (is_chg && cmd_p1 != P1_PLAIN) || (is_dis && !p1_ok)) begin
            next_sw = SW_P1P2; // [RL19]
         end else if (code_blk[idx]) begin
            next_sw = SW_BLOCKED; // [RL1] [RL5] [RL7]
         end else if (code_dis[idx]) begin
            next_sw = SW_STATE; // [RL1] [RL7]
         end else if (match) begin
            next_sw = SW_OK;
            irq_ev[IRQ_SE] = is_dis; // [RL16]
         end else begin
            next_sw = SW_RETRY_BASE | {14'h0, retry[idx] - 2'h1}; // [RL18]
            irq_ev[IRQ_FAIL] = 1'b1;
            irq_ev[IRQ_BLOCK] = fail_blk; // [RL5]
         end
      end
      irq_clr = 4'h0;
      if (apb_wr && paddr_in == ADDR_IRQ_ST) begin
         irq_clr = pwdata_in[3:0];
      end
      // a new event wins over a clear in the same cycle
      next_irq_st = (irq_st & ~irq_clr) | irq_ev;
   end

   logic exec_ok;
   assign exec_ok = (state == PCD_EXEC) && (is_chg || is_dis) && p2_ok &&
      (is_chg ? (cmd_lc == LC_CHANGE && cmd_p1 == P1_PLAIN) :
      (cmd_lc == LC_DISABLE && p1_ok)) && !code_blk[idx] && !code_dis[idx];

   // per code state, one shared store serves all channels
   logic [63:0] next_code_val [NUM_CODES];
   logic [1:0] next_retry [NUM_CODES];
   logic next_code_dis [NUM_CODES];
   logic next_code_blk [NUM_CODES];
   logic next_subst_used [NUM_CODES];
   logic [4:0] next_subst_ref [NUM_CODES];
   logic [7:0] next_qual [NUM_CODES];
   generate
      for (genvar g = 0; g < NUM_CODES; g++) begin : g_code
         // next values of one code
         always_comb begin
            next_code_val[g] = code_val[g];
            next_retry[g] = retry[g];
            next_code_dis[g] = code_dis[g];
            next_code_blk[g] = code_blk[g];
            next_subst_used[g] = subst_used[g];
            next_subst_ref[g] = subst_ref[g];
            next_qual[g] = qual[g];
            if (prov_we && prov_idx == 5'(g)) begin
               // provisioning and unblock path
               next_code_val[g] = new_code;
               next_retry[g] = RETRY_INIT;
               next_code_blk[g] = 1'b0;
               next_code_dis[g] = 1'b0;
               next_subst_used[g] = 1'b0;
            end else if (exec_ok && idx == 5'(g)) begin
               if (match) begin
                  next_retry[g] = RETRY_INIT; // [RL2] [RL8]
                  if (is_chg) begin
                     next_code_val[g] = new_code; // [RL2] [RL4]
                  end else begin
                     next_code_dis[g] = 1'b1; // [RL8] [RL14]
                     next_subst_used[g] = subst_req;
                     next_subst_ref[g] = cmd_p1[4:0];
                  end
               end else begin
                  next_retry[g] = retry[g] - 2'h1; // [RL3] [RL9]
                  next_code_blk[g] = (retry[g] == 2'h1); // [RL5]
               end
            end
            if (exec_ok && is_dis && match && subst_req && cmd_p1[4:0] == 5'(g)) begin
               next_qual[g] = QUAL_USE; // [RL13]
            end
         end
         // register stage of one code
         always_ff @(posedge mclk_in) begin
            if (sys_rst_in) begin
               retry[g] <= RETRY_INIT;
               code_dis[g] <= 1'b0;
               code_blk[g] <= 1'b0;
               subst_used[g] <= 1'b0;
               subst_ref[g] <= 5'h00;
               qual[g] <= QUAL_NOUSE;
               code_val[g] <= 64'h0;
            end else begin
               retry[g] <= next_retry[g];
               code_dis[g] <= next_code_dis[g];
               code_blk[g] <= next_code_blk[g];
               subst_used[g] <= next_subst_used[g];
               subst_ref[g] <= next_subst_ref[g];
               qual[g] <= next_qual[g];
               code_val[g] <= next_code_val[g];
            end
         end
      end
   endgenerate

   // access evaluation for a file guarded by the codes in file_refs
   logic access_ok;
   always_comb begin
      logic any_dis_plain, any_open;
      any_dis_plain = 1'b0;
      any_open = 1'b0;
      for (int i = 0; i < NUM_CODES; i++) begin
         if (file_refs[i] && code_dis[i] && !subst_used[i]) begin
            any_dis_plain = 1'b1; // [RL14] [RL15]
         end
         if (file_refs[i] && code_dis[i] && subst_used[i] &&
            ($countones(file_refs) > 1)) begin
            any_open = 1'b1; // [RL15]
         end
      end
      access_ok = (file_refs != '0) && (any_dis_plain || any_open);
   end

   // apb register next values
   logic [7:0] next_cmd_ins, next_cmd_lc, next_cmd_p1, next_cmd_p2;
   logic [63:0] next_old_code, next_new_code;
   logic [3:0] next_irq_mask;
   logic [NUM_CODES-1:0] next_file_refs;
   logic next_start, next_busy, next_prov_we;
   logic [4:0] next_prov_idx;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr, next_irq, next_se_eval;
   always_comb begin
      next_cmd_ins = cmd_ins;
      next_cmd_lc = cmd_lc;
      next_cmd_p1 = cmd_p1;
      next_cmd_p2 = cmd_p2;
      next_old_code = old_code;
      next_new_code = new_code;
      next_irq_mask = irq_mask;
      next_file_refs = file_refs;
      next_start = 1'b0;
      next_busy = busy;
      next_prov_we = 1'b0;
      next_prov_idx = prov_idx;
      next_prdata = prdata_out;
      // ready answers one cycle after setup, no wait states
      next_pready = psel_in && !penable_in;
      next_pslverr = 1'b0;
      next_irq = |(next_irq_st & irq_mask);
      next_se_eval = exec_ok && is_dis && match; // [RL16]
      if (state == PCD_DONE) begin
         next_busy = 1'b0;
      end
      if (psel_in && !penable_in) begin
         next_pslverr = !(paddr_in <= ADDR_PROV && paddr_in[1:0] == 2'h0);
         case (paddr_in)
            ADDR_STAT: next_prdata = {28'h0, code_blk[idx], code_dis[idx],
               retry[idx] == 2'h0, busy};
            ADDR_CMD: next_prdata = {24'h0, cmd_ins};
            ADDR_PAR: next_prdata = {8'h0, cmd_lc, cmd_p1, cmd_p2};
            ADDR_OLD_LO: next_prdata = word_sel(old_code, 1'b0);
            ADDR_OLD_HI: next_prdata = word_sel(old_code, 1'b1);
            ADDR_NEW_LO: next_prdata = word_sel(new_code, 1'b0);
            ADDR_NEW_HI: next_prdata = word_sel(new_code, 1'b1);
            ADDR_SW: next_prdata = {16'h0, sw};
            ADDR_IRQ_ST: next_prdata = {28'h0, irq_st};
            ADDR_IRQ_MASK: next_prdata = {28'h0, irq_mask};
            ADDR_CODE_ST: next_prdata = {14'h0, qual[idx], subst_ref[idx], subst_used[idx],
               retry[idx], code_blk[idx], code_dis[idx]};
            ADDR_ACCESS: next_prdata = {31'h0, access_ok};
            default: next_prdata = 32'h0;
         endcase
      end
      // writes while a command runs are dropped, except irq status clears
      if (apb_wr && !busy) begin
         case (paddr_in)
            ADDR_CTRL: begin
               next_start = pwdata_in[0];
               next_busy = pwdata_in[0];
               next_prov_we = pwdata_in[1];
               next_prov_idx = pwdata_in[12:8];
            end
            ADDR_CMD: next_cmd_ins = pwdata_in[7:0];
            ADDR_PAR: begin
               next_cmd_lc = pwdata_in[23:16];
               next_cmd_p1 = pwdata_in[15:8];
               next_cmd_p2 = pwdata_in[7:0];
            end
            ADDR_OLD_LO: next_old_code[31:0] = pwdata_in;
            ADDR_OLD_HI: next_old_code[63:32] = pwdata_in;
            ADDR_NEW_LO: next_new_code[31:0] = pwdata_in;
            ADDR_NEW_HI: next_new_code[63:32] = pwdata_in;
            ADDR_IRQ_MASK: next_irq_mask = pwdata_in[3:0];
            ADDR_ACCESS: next_file_refs = pwdata_in;
            default: ;
         endcase
      end
   end

   // apb registers
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         cmd_ins <= 8'h00;
         cmd_lc <= 8'h00;
         cmd_p1 <= 8'h00;
         cmd_p2 <= 8'h00;
         old_code <= 64'h0;
         new_code <= 64'h0;
         sw <= 16'h0000;
         irq_st <= 4'h0;
         irq_mask <= 4'h0;
         file_refs <= '0;
         start <= 1'b0;
         busy <= 1'b0;
         prov_we <= 1'b0;
         prov_idx <= 5'h00;
         prdata_out <= 32'h0;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         irq_out <= 1'b0;
         se_eval_out <= 1'b0;
      end else begin
         cmd_ins <= next_cmd_ins;
         cmd_lc <= next_cmd_lc;
         cmd_p1 <= next_cmd_p1;
         cmd_p2 <= next_cmd_p2;
         old_code <= next_old_code;
         new_code <= next_new_code;
         sw <= next_sw;
         irq_st <= next_irq_st;
         irq_mask <= next_irq_mask;
         file_refs <= next_file_refs;
         start <= next_start;
         busy <= next_busy;
         prov_we <= next_prov_we;
         prov_idx <= next_prov_idx;
         prdata_out <= next_prdata;
         pready_out <= next_pready;
         pslverr_out <= next_pslverr;
         irq_out <= next_irq;
         se_eval_out <= next_se_eval; // [RL16]
      end
   end
endmodule

/* inc/pcd_pkg.sv */
// constants and types for the code change and disable handler
// Notes on behaviour
// [RL1] change acts only when code enabled, unblocked
// [RL2] change match: counter to 3, store new
// [RL3] change mismatch: decrement counter, keep value
// [RL4] new code effective on every channel
// [RL5] three failures block code until unblock
// [RL6] terminal sends change with P1 00, Lc 10
// [RL7] disable refused when disabled or blocked
// [RL8] disable match: counter to 3, disabled
// [RL9] disable mismatch: decrement, stay enabled
// [RL10] terminal sends disable with Lc 08
// [RL11] P1 00 plain, 01 reserved, others unused
// [RL12] P1 b8 substitute key, b7 b6 zero
// [RL13] substitute key qualifier set to use 08
// [RL14] disabled code grants access or substitute
// [RL15] multi key files open once any disabled
// [RL16] re-evaluate security environment after disable
// [RL17] P2 low five bits reference, top global
// [RL18] failures answer 63C2, 63C1, 63C0
// [RL19] bad length or parameters rejected untouched
package pcd_pkg;
   localparam int NUM_CODES = 32;
   localparam logic [1:0] RETRY_INIT = 2'h3;
   localparam logic [7:0] LC_CHANGE = 8'h10;
   localparam logic [7:0] LC_DISABLE = 8'h08;
   localparam logic [7:0] P1_PLAIN = 8'h00;
   localparam logic [7:0] P1_RESERVED = 8'h01;
   localparam int P1_SUBST_BIT = 7;
   localparam logic [7:0] QUAL_USE = 8'h08;
   localparam logic [7:0] QUAL_NOUSE = 8'h00;
   localparam logic [7:0] CMD_CHANGE = 8'h24;
   localparam logic [7:0] CMD_DISABLE = 8'h26;
   localparam logic [15:0] SW_OK = 16'h9000;
   localparam logic [15:0] SW_RETRY_BASE = 16'h63C0;
   localparam logic [15:0] SW_BLOCKED = 16'h6983;
   localparam logic [15:0] SW_STATE = 16'h6985;
   localparam logic [15:0] SW_P1P2 = 16'h6B00;
   localparam logic [15:0] SW_LEN = 16'h6700;
   localparam logic [15:0] SW_INS = 16'h6D00;
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STAT = 12'h004;
   localparam logic [11:0] ADDR_CMD = 12'h008;
   localparam logic [11:0] ADDR_PAR = 12'h00C;
   localparam logic [11:0] ADDR_OLD_LO = 12'h010;
   localparam logic [11:0] ADDR_OLD_HI = 12'h014;
   localparam logic [11:0] ADDR_NEW_LO = 12'h018;
   localparam logic [11:0] ADDR_NEW_HI = 12'h01C;
   localparam logic [11:0] ADDR_SW = 12'h020;
   localparam logic [11:0] ADDR_IRQ_ST = 12'h024;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h028;
   localparam logic [11:0] ADDR_CODE_ST = 12'h02C;
   localparam logic [11:0] ADDR_ACCESS = 12'h030;
   localparam logic [11:0] ADDR_PROV = 12'h034;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_FAIL = 1;
   localparam int IRQ_BLOCK = 2;
   localparam int IRQ_SE = 3;
   typedef enum logic [2:0] {
      PCD_IDLE = 3'b001,
      PCD_EXEC = 3'b010,
      PCD_DONE = 3'b100
   } pcd_state_t;
endpackage

/* tb/pcd_terminal.sv */
// terminal model issuing commands over apb
`timescale 1ns/100ps
module pcd_terminal
   import pcd_pkg::*;
(
   input wire logic mclk_in,
   output logic psel_out = 1'b0,
   output logic penable_out = 1'b0,
   output logic pwrite_out = 1'b0,
   output logic [11:0] paddr_out = 12'h000,
   output logic [31:0] pwdata_out = 32'h0,
   input wire logic [31:0] prdata_in,
   input wire logic pready_in,
   input wire logic pslverr_in
);
   logic err;
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
      psel_out <= 1'b1;
      pwrite_out <= w;
      paddr_out <= a;
      pwdata_out <= d;
      @(posedge mclk_in);
      penable_out <= 1'b1;
      @(posedge mclk_in);
      while (pready_in !== 1'b1)
         @(posedge mclk_in);
      q = prdata_in;
      err = pslverr_in;
      psel_out <= 1'b0;
      penable_out <= 1'b0;
      pwdata_out <= ~d;
      @(posedge mclk_in);
   endtask
   // codes go out as whole words, then start, then busy is polled
   task automatic cmd(input logic [7:0] ins, lc, p1, p2, input logic [63:0] o, n,
      output logic [15:0] sw);
      logic [31:0] q;
      xfer(1'b1, ADDR_PAR, {8'h00, lc, p1, p2}, q);
      xfer(1'b1, ADDR_OLD_LO, o[31:0], q);
      xfer(1'b1, ADDR_OLD_HI, o[63:32], q);
      xfer(1'b1, ADDR_NEW_LO, n[31:0], q);
      xfer(1'b1, ADDR_NEW_HI, n[63:32], q);
      xfer(1'b1, ADDR_CMD, {24'h000000, ins}, q);
      xfer(1'b1, ADDR_CTRL, 32'h1, q);
      q = 32'h1;
      while (q[0] !== 1'b0)
         xfer(1'b0, ADDR_STAT, 32'h0, q);
      xfer(1'b0, ADDR_SW, 32'h0, q);
      sw = q[15:0];
   endtask
endmodule

/* tb/pcd_handler_props.sv */
// assertions on the handler ports
`timescale 1ns/100ps
module pcd_handler_props
   import pcd_pkg::*;
(
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic irq_out,
   input wire logic se_eval_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   logic wr_en;
   assign wr_en = psel_in && penable_in && pwrite_in && pready_out;
   ready_a: assert property (psel_in && !penable_in |=> pready_out) else $error("no ready");
   ready_once_a: assert property (pready_out |=> !pready_out) else $error("ready held");
   ready_idle_a: assert property (!psel_in |=> !pready_out) else $error("stray ready");
   bad_addr_a: assert property (psel_in && !penable_in && (paddr_in > ADDR_PROV
      || paddr_in[1:0] != 2'h0) |=> pslverr_out) else $error("no slave error");
   err_ready_a: assert property (pslverr_out |-> pready_out) else $error("lone error");
   se_once_a: assert property (se_eval_out |=> !se_eval_out)
      else $error("se held");
   irq_mask_a: assert property (wr_en && paddr_in == ADDR_IRQ_MASK
      && pwdata_in[3:0] == 4'h0 |-> ##2 !irq_out) else $error("masked irq");
   rst_out_a: assert property (disable iff (1'b0) sys_rst_in |=> !pready_out && !irq_out)
      else $error("output in reset");
endmodule
bind pcd_handler pcd_handler_props chk (
   .mclk_in(mclk_in),
   .sys_rst_in(sys_rst_in),
   .psel_in(psel_in),
   .penable_in(penable_in),
   .pwrite_in(pwrite_in),
   .paddr_in(paddr_in),
   .pwdata_in(pwdata_in),
   .pready_out(pready_out),
   .pslverr_out(pslverr_out),
   .irq_out(irq_out),
   .se_eval_out(se_eval_out)
);

/* tb/pcd_handler_test.sv */
// self-checking bench for the code handler
`timescale 1ns/100ps
module pcd_handler_test
   import pcd_pkg::*;
   ;
   logic clk, rst, sel, en, wr, rdy, err, irq, se;
   logic [11:0] ad;
   logic [31:0] wd, rd, q;
   logic [15:0] sw;
   logic [63:0] c1, c2;
   logic [7:0] k, j;
   int n_errors = 0;
   int n_tests = 0;
   int seed = 74901;
   int n_se = 0;
   always @(posedge clk) begin
      if (se === 1'b1) begin
         n_se++;
      end
   end
   pcd_handler dut (.mclk_in(clk), .sys_rst_in(rst), .psel_in(sel), .penable_in(en),
      .pwrite_in(wr), .paddr_in(ad), .pwdata_in(wd), .prdata_out(rd), .pready_out(rdy),
      .pslverr_out(err), .irq_out(irq), .se_eval_out(se));
   pcd_terminal term (.mclk_in(clk), .psel_out(sel), .penable_out(en), .pwrite_out(wr),
      .paddr_out(ad), .pwdata_out(wd), .prdata_in(rd), .pready_in(rdy), .pslverr_in(err));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask
   task end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   function logic [15:0] fail_sw(input int left);
      return SW_RETRY_BASE | 16'(left);
   endfunction
   function logic [31:0] st_word(input logic [1:0] r, input logic b, input logic d);
      return {28'h0, r, b, d};
   endfunction
   task wrt(input logic [11:0] a, input logic [31:0] d);
      term.xfer(1'b1, a, d, q);
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      term.xfer(1'b0, a, 32'h0, q);
      check(q & m, e);
   endtask
   task cmdc(input logic [7:0] i, l, p1, p2, input logic [63:0] o, input logic [15:0] e);
      term.cmd(i, l, p1, p2, o, c2, sw);
      check({16'h0, sw}, {16'h0, e});
   endtask
   task prov(input logic [7:0] i, input logic [63:0] c);
      wrt(ADDR_NEW_LO, c[31:0]);
      wrt(ADDR_NEW_HI, c[63:32]);
      wrt(ADDR_CTRL, {19'h0, i[4:0], 8'h02});
   endtask
   task irqc(input logic e);
      @(posedge clk);
      check({31'h0, irq}, {31'h0, e});
   endtask
   initial begin
      repeat (8000) @(posedge clk);
      n_errors++;
      end_of_test();
   end
   initial begin
      rst = 1'b1;
      k = 8'h01 + (8'($random(seed)) & 8'h0E);
      j = k + 8'h10;
      c1 = {$random(seed), $random(seed)};
      c2 = {$random(seed), $random(seed)};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      prov(k, c1);
      wrt(ADDR_IRQ_MASK, 32'hF);
      cmdc(CMD_CHANGE, LC_DISABLE, P1_PLAIN, k, c1, SW_LEN);
      rdc(ADDR_CODE_ST, 32'hF, st_word(2'h3, 1'b0, 1'b0));
      cmdc(CMD_CHANGE, LC_CHANGE, P1_PLAIN, k, ~c1, fail_sw(2));
      rdc(ADDR_CODE_ST, 32'hF, st_word(2'h2, 1'b0, 1'b0));
      cmdc(CMD_CHANGE, LC_CHANGE, P1_PLAIN, k, c1, SW_OK);
      rdc(ADDR_CODE_ST, 32'hF, st_word(2'h3, 1'b0, 1'b0));
      cmdc(CMD_DISABLE, LC_DISABLE, P1_PLAIN, k, c1, fail_sw(2));
      rdc(ADDR_CODE_ST, 32'hF, st_word(2'h2, 1'b0, 1'b0));
      cmdc(CMD_DISABLE, LC_DISABLE, P1_RESERVED, k, c2, SW_P1P2);
      cmdc(CMD_DISABLE, LC_DISABLE, 8'hC0 | k, k, c2, SW_P1P2);
      cmdc(CMD_DISABLE, LC_DISABLE, P1_PLAIN, k, c2, SW_OK);
      rdc(ADDR_CODE_ST, 32'hF, st_word(2'h3, 1'b0, 1'b1));
      cmdc(CMD_DISABLE, LC_DISABLE, P1_PLAIN, k, c2, SW_STATE);
      cmdc(CMD_CHANGE, LC_CHANGE, P1_PLAIN, k, c2, SW_STATE);
      wrt(ADDR_ACCESS, 32'h1 << k);
      rdc(ADDR_ACCESS, 32'h1, 32'h1);
      wrt(ADDR_ACCESS, (32'h1 << k) | (32'h2 << k));
      rdc(ADDR_ACCESS, 32'h1, 32'h1);
      prov(j, c1);
      cmdc(CMD_DISABLE, LC_DISABLE, 8'h80 | k, j, c1, SW_OK);
      wrt(ADDR_PAR, {24'h0, k});
      rdc(ADDR_CODE_ST, 32'h3FC00, {14'h0, QUAL_USE, 10'h0});
      prov(j, c1);
      for (int i = 2; i >= 0; i--) begin
         cmdc(CMD_CHANGE, LC_CHANGE, P1_PLAIN, j, ~c1, fail_sw(i));
      end
      rdc(ADDR_STAT, 32'h8, 32'h8);
      cmdc(CMD_CHANGE, LC_CHANGE, P1_PLAIN, j, c1, SW_BLOCKED);
      cmdc(CMD_DISABLE, LC_DISABLE, P1_PLAIN, j, c1, SW_BLOCKED);
      irqc(1'b1);
      wrt(ADDR_IRQ_MASK, 32'h0);
      irqc(1'b0);
      wrt(ADDR_IRQ_MASK, 32'hF);
      irqc(1'b1);
      wrt(ADDR_IRQ_ST, 32'hF);
      irqc(1'b0);
      term.xfer(1'b0, 12'h040, 32'h0, q);
      check({31'h0, term.err}, 32'h1);
      check(32'(n_se), 32'h2);
      end_of_test();
   end
endmodule
